/* core/conv_link_defs.svh */
`ifndef CONV_LINK_DEFS_SVH
`define CONV_LINK_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define CODE_W            8
`define MUX_W             4

// ****************************************************************
// Timing (system clock is 100 MHz)
// ****************************************************************
`define CLK_PERIOD_NS     10
// Clock and select both high for this long clears the link
`define RESET_HOLD_NS     50
// Least time, so round up to whole cycles
`define RESET_HOLD_CYC    ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Serial sequence counts
// ****************************************************************
// Falling edges that end the 1.5 period sampling window
`define SAMPLE_FALLS      4'h2
// One extra period on the four and single channel variants
`define SAMPLE_FALLS_EXT  4'h3
// Address bits after the start bit
`define ADDR_BITS_FOUR    4'h3
`define ADDR_BITS_EIGHT   4'h4
// Index of the last bit of a stream
`define LAST_BIT          4'h7
// LSB-first stream finished
`define LSB_DONE          4'h8
// Longest conversion in link clock periods
`define CONV_PERIODS      4'h8
`define ZERO_CODE         8'h00

`endif

/* core/conv_link_pkg.sv */
package conv_link_pkg;

	// Link sequence states
	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_MSB    = 3'b011,
		ST_LSB    = 3'b100,
		ST_TAIL   = 3'b101
	} conv_state_e;

	// Device variant strap
	typedef enum logic [1:0]
	{
		VAR_SINGLE = 2'b00,
		VAR_FOUR   = 2'b01,
		VAR_EIGHT  = 2'b10
	} variant_e;

endpackage

/* core/sar_result.sv */
`timescale 1ns/1ps
`include "conv_link_defs.svh"

module sar_result
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 capture,
	input  wire logic [`CODE_W-1:0]   ain_pos,
	input  wire logic [`CODE_W-1:0]   ain_neg,
	output logic      [`CODE_W-1:0]   code
);

	// ****************************************************************
	// Conversion result
	// ****************************************************************
	logic [`CODE_W-1:0] code_reg;   // Held result
	logic [`CODE_W-1:0] code_next;  // Next result

	// Difference of the inputs, all zeros when minus is not below plus
	always_comb
	begin
		code_next = code_reg;
		if (capture)
		begin
			if (ain_neg >= ain_pos)
				code_next = `ZERO_CODE;
			else
				code_next = ain_pos - ain_neg;
		end
	end

	// Register the result
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			code_reg <= `ZERO_CODE;
		else
			code_reg <= code_next;
	end

	assign code = code_reg;

endmodule

/* core/conv_link.sv */
// Functional notes
// - Conversion finishes within eight clock periods
// - Four and single channel add sampling period
// - Clock and select high together resets
// - Data-in sampled on rising clock edge
// - Data-out changes after falling clock edge
// - Select high floats data-out and busy flag
// - Minus at or above plus gives zero
// - Shift request high holds LSB on output (eight channel only)
// - Single channel outputs MSB first only
// - Skip leading zeros, start bit, address
// - After sampling raise busy, leading zero
// - Auto LSB-first stream, then hold low
`timescale 1ns/1ps
`include "conv_link_defs.svh"

module conv_link
(
	input  wire logic                       CLK,
	input  wire logic                       RESETN,
	input  wire logic                       CS_N,
	input  wire logic                       SCLK,
	input  wire logic                       DI,
	input  wire logic                       LSB_SHIFT_REQUEST_N,
	input  wire conv_link_pkg::variant_e    VARIANT,
	input  wire logic [`CODE_W-1:0]         AIN_POS,
	input  wire logic [`CODE_W-1:0]         AIN_NEG,
	output logic                            DO_O,
	output logic                            DO_OE_N,
	output logic                            CONVERSION_IN_PROGRESS_FLAG_O,
	output logic                            CONVERSION_IN_PROGRESS_FLAG_OE_N,
	output logic [`MUX_W-1:0]               MUX_ADDR
);
	import conv_link_pkg::*;
	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_reg;  // First release stage
	logic rst_n;         // Released reset copy

	// Two stage release, only the second stage reads the first
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			{rst_n, rst_meta_reg} <= 2'b00;
		else
			{rst_n, rst_meta_reg} <= {rst_meta_reg, 1'b1};
	end

	// ****************************************************************
	// Link state
	// ****************************************************************
	conv_state_e        state_reg, state_next;     // Sequence state
	logic               sclk_reg, sclk_next;       // Previous link clock
	logic               started_reg, started_next; // Start bit seen
	logic [3:0]         cnt_reg, cnt_next;         // Bit and edge count
	logic [2:0]         hold_reg, hold_next;       // Reset hold count
	logic [`MUX_W-1:0]  mux_reg, mux_next;         // Address word
	logic               do_reg, do_next;           // Data-out level
	logic               do_oe_n_reg, do_oe_n_next; // Data-out enable
	logic               busy_reg, busy_next;       // Busy flag level
	logic               busy_oe_n_reg, busy_oe_n_next;
	logic               capture;                   // Take the result
	logic [`CODE_W-1:0] code;                      // Held result
	logic               rise;                      // Link clock rose
	logic               fall;                      // Link clock fell
	logic [3:0]         addr_bits;                 // Address length
	logic [3:0]         samp_falls;                // Sampling length
	logic               hold_done;                 // Reset interval met

	assign rise = SCLK & ~sclk_reg;
	assign fall = ~SCLK & sclk_reg;
	assign hold_done = (hold_reg == 3'(`RESET_HOLD_CYC));
	// Variant dependent lengths, no address word on single channel
	assign addr_bits  = (VARIANT == VAR_EIGHT) ? `ADDR_BITS_EIGHT
		: (VARIANT == VAR_FOUR) ? `ADDR_BITS_FOUR : 4'h0;
	// Only the eight channel lacks the extra sampling period
	assign samp_falls = (VARIANT == VAR_EIGHT) ? `SAMPLE_FALLS
		: `SAMPLE_FALLS_EXT;

	// Next values of the link sequence
	always_comb
	begin
		state_next     = state_reg;
		sclk_next      = SCLK;
		started_next   = started_reg;
		cnt_next       = cnt_reg;
		hold_next      = 3'h0;
		mux_next       = mux_reg;
		do_next        = do_reg;
		do_oe_n_next   = do_oe_n_reg;
		busy_next      = busy_reg;
		busy_oe_n_next = busy_oe_n_reg;
		capture        = 1'b0;
		if (CS_N)
		begin
			// Select high floats both outputs
			do_oe_n_next   = 1'b1;
			busy_oe_n_next = 1'b1;
			// Count clock and select high together
			if (SCLK && !hold_done)
				hold_next = hold_reg + 3'h1;
			else if (SCLK)
				hold_next = hold_reg;
			if (hold_done)
			begin
				// Interval met: clear internal state
				state_next   = ST_IDLE;
				started_next = 1'b0;
				cnt_next     = 4'h0;
				mux_next     = '0;
				do_next      = 1'b0;
				busy_next    = 1'b0;
			end
		end
		else
		begin
			case (state_reg)
				// Select low opens the address phase
				ST_IDLE: state_next = ST_ADDR;
				ST_ADDR:
				begin
					// Data-in taken on rising edges
					if (rise && !started_reg && DI)
					begin
						// First one is the start bit
						started_next = 1'b1;
						cnt_next     = 4'h0;
						if (addr_bits == 4'h0)
							state_next = ST_SAMPLE;
					end
					else if (rise && started_reg)
					begin
						// Address bits after the start bit
						mux_next = {mux_reg[`MUX_W-2:0], DI};
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg + 4'h1 == addr_bits)
						begin
							state_next = ST_SAMPLE;
							cnt_next   = 4'h0;
						end
					end
				end
				ST_SAMPLE:
				begin
					// Sampling window counted in falling edges
					if (fall)
					begin
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg + 4'h1 == samp_falls)
						begin
							// Busy high, output leaves float
							busy_next      = 1'b1;
							busy_oe_n_next = 1'b0;
							do_next        = 1'b0;
							do_oe_n_next   = 1'b0;
							capture        = 1'b1;
							cnt_next       = 4'h0;
							state_next     = ST_MSB;
						end
					end
				end
				ST_MSB:
				begin
					// MSB first, one bit per falling edge
					if (fall && busy_reg && cnt_reg <= `LAST_BIT)
					begin
						do_next  = code[3'(`LAST_BIT - cnt_reg)];
						cnt_next = cnt_reg + 4'h1;
					end
					else if (rise && cnt_reg == `CONV_PERIODS)
					begin
						// Busy ends half a period after the LSB
						busy_next  = 1'b0;
						cnt_next   = 4'h1;
						state_next = ST_LSB;
					end
				end
				ST_LSB:
				begin
					// Single channel keeps the LSB, no second stream
					if (VARIANT == VAR_SINGLE)
						do_next = do_reg;
					else if (fall && (VARIANT == VAR_FOUR
						|| !LSB_SHIFT_REQUEST_N))
					begin
						if (cnt_reg == `LSB_DONE)
						begin
							// Stream done, hold low
							do_next    = 1'b0;
							state_next = ST_TAIL;
						end
						else
						begin
							do_next  = code[3'(cnt_reg)];
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				// Data-out stays low until select rises
				ST_TAIL: do_next = 1'b0;
				default: state_next = ST_IDLE;
			endcase
		end
	end

	// Register the link state
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= ST_IDLE;
			sclk_reg      <= 1'b0;
			started_reg   <= 1'b0;
			cnt_reg       <= 4'h0;
			hold_reg      <= 3'h0;
			mux_reg       <= '0;
			do_reg        <= 1'b0;
			do_oe_n_reg   <= 1'b1;
			busy_reg      <= 1'b0;
			busy_oe_n_reg <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			sclk_reg      <= sclk_next;
			started_reg   <= started_next;
			cnt_reg       <= cnt_next;
			hold_reg      <= hold_next;
			mux_reg       <= mux_next;
			do_reg        <= do_next;
			do_oe_n_reg   <= do_oe_n_next;
			busy_reg      <= busy_next;
			busy_oe_n_reg <= busy_oe_n_next;
		end
	end

	// ****************************************************************
	// Result capture
	// ****************************************************************
	sar_result u_result
	(
		.clk     (CLK),
		.rst_n   (rst_n),
		.capture (capture),
		.ain_pos (AIN_POS),
		.ain_neg (AIN_NEG),
		.code    (code)
	);

	assign DO_O                             = do_reg;
	assign DO_OE_N                          = do_oe_n_reg;
	assign CONVERSION_IN_PROGRESS_FLAG_O    = busy_reg;
	assign CONVERSION_IN_PROGRESS_FLAG_OE_N = busy_oe_n_reg;
	assign MUX_ADDR                         = mux_reg;
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);
	logic [3:0] busy_falls_reg;  // Falling edges while busy
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			busy_falls_reg <= 4'h0;
		else if (!busy_reg)
			busy_falls_reg <= 4'h0;
		else if (fall && busy_falls_reg != 4'hf)
			busy_falls_reg <= busy_falls_reg + 4'h1;
	end
	sequence s_start;
		state_reg == ST_ADDR && !CS_N && rise && DI && !started_reg;
	endsequence
	sequence s_addr_bit;
		state_reg == ST_ADDR && !CS_N && rise && started_reg;
	endsequence
	a_float_on_select: assert property (CS_N |=> DO_OE_N && CONVERSION_IN_PROGRESS_FLAG_OE_N) else $error("outputs not floated");
	a_reset_clears: assert property (CS_N && hold_done |=> state_reg == ST_IDLE && !busy_reg) else $error("reset not applied");
	a_no_hold_low_select: assert property (!CS_N |=> hold_reg == 3'h0) else $error("hold count with select low");
	a_busy_rise_zero: assert property ($rose(busy_reg) |-> !do_reg && !do_oe_n_reg && !busy_oe_n_reg) else $error("no leading zero");
	a_msb_on_fall: assert property (state_reg == ST_MSB && !CS_N && !fall |=> $stable(do_reg)) else $error("data-out moved off edge");
	a_conv_length: assert property ($fell(busy_reg) && !$past(CS_N) |-> busy_falls_reg <= `CONV_PERIODS) else $error("conversion too long");
	a_zero_code: assert property (capture && AIN_NEG >= AIN_POS |=> code == `ZERO_CODE) else $error("negative input not zero code");
	a_single_holds: assert property (state_reg == ST_LSB && VARIANT == VAR_SINGLE && !CS_N |=> $stable(do_reg)) else $error("single channel shifted");
	a_shift_hold: assert property (state_reg == ST_LSB && VARIANT == VAR_EIGHT && LSB_SHIFT_REQUEST_N && !CS_N |=> $stable(do_reg)) else $error("lsb not held");
	a_tail_low: assert property (state_reg == ST_TAIL && !CS_N |=> !do_reg) else $error("tail not low");
	a_start_taken: assert property (s_start |=> started_reg) else $error("start bit missed");
	a_addr_shift: assert property (s_addr_bit |=> mux_reg == {$past(mux_reg[`MUX_W-2:0]), $past(DI)}) else $error("address bit wrong");
	a_di_ignored: assert property (state_reg inside {ST_MSB, ST_LSB, ST_TAIL} && !(CS_N && hold_done) |=> $stable(mux_reg)) else $error("data-in accepted");
endmodule

/* test/host_link_model.sv */
`timescale 1ns/1ps

module host_link_model
(
	input  wire logic CLK,
	input  wire logic DO_O,
	input  wire logic DO_OE_N,
	input  wire logic FLAG_O,
	output logic      CS_N,
	output logic      SCLK,
	output logic      DI
);
	// ****************************************
	// Capture per link period: flag, oe_n, data
	// ****************************************
	logic [2:0] cap [0:27];

	// Idle: deselected, link clock still
	initial
	begin
		CS_N = 1'h1;
		SCLK = 1'h0;
		DI = 1'h0;
	end

	// Step n system cycles, inputs move just after the edge
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge CLK);
			#1;
		end
	endtask

	// Clock and select high together, longer than the hold
	task automatic reset_hold();
		CS_N = 1'h1;
		SCLK = 1'h1;
		tick(8);
		SCLK = 1'h0;
		tick(2);
	endtask

	// One frame of 28 link periods, then deselect
	task automatic frame(input logic [27:0] seq);
		CS_N = 1'h0;
		tick(2);
		for (int p = 0; p < 28; p++)
		begin
			// Data moves in the low phase, valid at the rise
			DI = seq[27-p];
			tick(12);
			SCLK = 1'h1;
			// Bit launched by the last fall is read at the rise
			cap[p] = {FLAG_O, DO_OE_N, DO_O};
			tick(13);
			SCLK = 1'h0;
		end
		tick(12);
		CS_N = 1'h1;
		tick(3);
	endtask
endmodule

/* test/test_serial_adc_conversion_link.sv */
`timescale 1ns/1ps

module test_serial_adc_conversion_link;
	import conv_link_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic       clk;          // System clock
	logic       resetn;       // Async reset, low active
	logic       cs_n;         // Select from host
	logic       sclk;         // Link clock from host
	logic       di;           // Serial data in
	logic       shift_req_n;  // LSB stream request
	variant_e   variant;      // Variant strap
	logic [7:0] ain_pos;      // Plus input
	logic [7:0] ain_neg;      // Minus input
	logic       do_o;         // Serial data out
	logic       do_oe_n;      // Data out enable
	logic       flag_o;       // Busy flag
	logic       flag_oe_n;    // Busy flag enable
	logic [3:0] mux_addr;     // Address word
	int         bad_count;    // Mismatches
	int         total_checks; // Comparisons
	int         cycles;       // Timeout counter

	// ****************************************
	// Instances
	// ****************************************
	conv_link dut
	(
		.CLK                              (clk),
		.RESETN                           (resetn),
		.CS_N                             (cs_n),
		.SCLK                             (sclk),
		.DI                               (di),
		.LSB_SHIFT_REQUEST_N              (shift_req_n),
		.VARIANT                          (variant),
		.AIN_POS                          (ain_pos),
		.AIN_NEG                          (ain_neg),
		.DO_O                             (do_o),
		.DO_OE_N                          (do_oe_n),
		.CONVERSION_IN_PROGRESS_FLAG_O    (flag_o),
		.CONVERSION_IN_PROGRESS_FLAG_OE_N (flag_oe_n),
		.MUX_ADDR                         (mux_addr)
	);

	host_link_model host
	(
		.CLK     (clk),
		.DO_O    (do_o),
		.DO_OE_N (do_oe_n),
		.FLAG_O  (flag_o),
		.CS_N    (cs_n),
		.SCLK    (sclk),
		.DI      (di)
	);

	// 100 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			test_done();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Set straps and inputs, clear the link, run a frame
	task automatic run(input variant_e v, input logic se_n,
		input logic [7:0] p, input logic [7:0] n, input logic [27:0] seq);
		variant = v;
		shift_req_n = se_n;
		ain_pos = p;
		ain_neg = n;
		host.reset_hold();
		chk({4'h0, mux_addr}, 8'h00);
		host.frame(seq);
		chk({6'h00, do_oe_n, flag_oe_n}, 8'h03);
	endtask

	// Judge captures; base is the period holding the MSB
	task automatic judge(input int b, input logic [7:0] code, input bit held);
		chk({5'h00, host.cap[b-2]}, 8'h02);
		chk({5'h00, host.cap[b-1]}, 8'h04);
		for (int i = 0; i < 8; i++)
			chk({5'h00, host.cap[b+i]}, {5'h00, 2'h2, code[7-i]});
		chk({7'h00, host.cap[b+8][2]}, 8'h00);
		for (int i = 1; i < 8; i++)
			chk(8'(host.cap[b+7+i][0]), 8'(held ? code[0] : code[i]));
		if (!held)
			chk({7'h00, host.cap[b+15][0]}, 8'h00);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic sc_eight_auto();
		run(VAR_EIGHT, 1'h0, 8'hC5, 8'h10, {7'h1B, 21'h1F_FFFF});
		judge(9, 8'hB5, 1'b0);
		chk({4'h0, mux_addr}, 8'h0B);
	endtask

	task automatic sc_eight_held();
		run(VAR_EIGHT, 1'h1, 8'h9A, 8'h01, {7'h1B, 21'h1F_FFFF});
		judge(9, 8'h99, 1'b1);
	endtask

	task automatic sc_four();
		run(VAR_FOUR, 1'h1, 8'h7E, 8'h00, {6'h0D, 22'h3F_FFFF});
		judge(9, 8'h7E, 1'b0);
		chk({4'h0, mux_addr}, 8'h05);
	endtask

	task automatic sc_single();
		run(VAR_SINGLE, 1'h0, 8'hF0, 8'h0F, {3'h1, 25'h1FF_FFFF});
		judge(6, 8'hE1, 1'b1);
	endtask

	task automatic sc_zero();
		run(VAR_EIGHT, 1'h0, 8'h40, 8'h40, {7'h1B, 21'h1F_FFFF});
		judge(9, 8'h00, 1'b0);
		run(VAR_EIGHT, 1'h0, 8'h20, 8'h80, {7'h1B, 21'h1F_FFFF});
		judge(9, 8'h00, 1'b0);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		resetn = 1'h0;
		shift_req_n = 1'h1;
		variant = VAR_EIGHT;
		ain_pos = 8'h00;
		ain_neg = 8'h00;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'h1;
		sc_eight_auto();
		sc_eight_held();
		sc_four();
		sc_single();
		sc_zero();
		test_done();
	end
endmodule
